//--- logic/fsc_defines.vh
// Register indices, field positions and reset values of the synthesizer control bank.
`ifndef FSC_DEFINES_VH
`define FSC_DEFINES_VH
// ----------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------
`define FSC_IDX_FB_HIGH      10'h022
`define FSC_IDX_FB_LOW       10'h024
`define FSC_IDX_SEED_DLY     10'h025
`define FSC_IDX_DEN_HIGH     10'h026
`define FSC_IDX_DEN_LOW      10'h027
`define FSC_IDX_SEED_HIGH    10'h028
`define FSC_IDX_SEED_LOW     10'h029
`define FSC_IDX_NUM_HIGH     10'h02a
`define FSC_IDX_NUM_LOW      10'h02b
`define FSC_IDX_PWR_MOD      10'h02c
`define FSC_IDX_SRC_BOOST    10'h02d
`define FSC_IDX_SECOND_SRC   10'h02e
`define FSC_IDX_LOCK_KIND    10'h03b
`define FSC_IDX_LOCK_DLY     10'h03c
`define FSC_IDX_SETTLE_HIGH  10'h045
`define FSC_IDX_SETTLE_LOW   10'h046
`define FSC_IDX_SYNC_CTL     10'h047
`define FSC_IDX_STATUS       10'h048
`define FSC_IDX_ACC_HIGH     10'h049
`define FSC_IDX_ACC_LOW      10'h04a
// ----------------------------------------
// Field positions
// ----------------------------------------
`define FSC_SEED_EN_BIT      15
`define FSC_DLY_SEL_LSB      8
`define FSC_PWR1_LSB         8
`define FSC_PD2_BIT          7
`define FSC_PD1_BIT          6
`define FSC_MRST_BIT         5
`define FSC_SRC1_LSB         11
`define FSC_BOOST_LSB        9
// ----------------------------------------
// Reset values
// ----------------------------------------
`define FSC_RST_FB_DIV       19'h00064
`define FSC_RST_DLY_SEL      6'h02
`define FSC_RST_DEN          32'hffffffff
`define FSC_RST_PWR          6'h1f
`define FSC_RST_SRC          2'h1
`define FSC_RST_LOCK_DLY     16'h03e8
`define FSC_RST_SETTLE       32'h0000c350
// ----------------------------------------
// Codes
// ----------------------------------------
`define FSC_ORDER_MAX        3'h4
`define FSC_SRC_HIZ          2'h3
`define FSC_SRC_RSVD         2'h2
`endif

//--- logic/fsc_control_regs.v
// APB register bank and control logic of a fractional-N synthesizer.
`timescale 1ns/10ps
`include "fsc_defines.vh"
module fsc_control_regs
(
   input  wire        i_clock,
   input  wire        i_reset_n,
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [11:0] i_paddr,
   input  wire [31:0] i_pwdata,
   input  wire        i_cal_done,
   input  wire        i_vtune_ok,
   input  wire        i_pd_tick,
   output wire        o_pready,
   output wire        o_pslverr,
   output reg  [31:0] o_prdata,
   output reg  [18:0] o_divide_integer,
   output reg  [31:0] o_fraction_num,
   output reg  [31:0] o_fraction_den,
   output reg  [31:0] o_seed_accum,
   output reg  [2:0]  o_modulator_order,
   output reg         o_modulator_reset,
   output reg  [5:0]  o_detector_delay_select,
   output reg  [5:0]  o_first_output_power,
   output reg  [5:0]  o_second_output_power,
   output reg  [1:0]  o_first_output_source,
   output reg  [1:0]  o_second_output_source,
   output reg         o_first_output_enable,
   output reg         o_second_output_enable,
   output reg  [1:0]  o_output_boost_sel,
   output reg         o_lock,
   output reg         o_divider_holdoff
);
// ----------------------------------------
// Register storage
// ----------------------------------------
reg [18:0] fb_div_reg;
reg        seed_apply_enable_reg;
reg [5:0]  detector_delay_select_reg;
reg [31:0] fraction_denominator_reg;
reg [15:0] seed_high_reg;
reg [15:0] seed_low_reg;
reg [31:0] fraction_numerator_reg;
reg [5:0]  first_output_power_reg;
reg        second_output_powerdown_reg;
reg        first_output_powerdown_reg;
reg        modulator_reset_ctl_reg;
reg [2:0]  modulator_order_sel_reg;
reg [1:0]  first_output_source_reg;
reg [1:0]  output_boost_sel_reg;
reg [5:0]  second_output_power_reg;
reg [1:0]  second_output_source_reg;
reg        lock_indicator_kind_reg;
reg [15:0] lock_indicator_delay_reg;
reg [31:0] post_reset_settle_count_reg;
reg        phase_sync_mode_reg;
reg [31:0] seed_accum_reg;
reg        mrst_prev_reg;
reg [31:0] settle_cnt_reg;
reg [15:0] lock_cnt_reg;
// ----------------------------------------
// Bus decode
// ----------------------------------------
wire [9:0] idx = i_paddr[11:2];
wire       wr_en = i_psel & i_penable & i_pwrite;
wire       setup = i_psel & ~i_penable;
reg        mapped;
reg [15:0] rd_val;
wire [2:0] order_eff;
wire       lock_cond;
wire       frac_on;
assign o_pready = 1'b1;
assign o_pslverr = i_psel & i_penable & ~mapped;
// Reserved order codes run the loop as integer, the safe choice.
assign order_eff = (modulator_order_sel_reg > `FSC_ORDER_MAX) ? 3'h0 :
                   modulator_order_sel_reg;
assign frac_on = ~modulator_reset_ctl_reg & (order_eff != 3'h0);
assign lock_cond = i_cal_done & (~lock_indicator_kind_reg | i_vtune_ok);
always @*
begin
   mapped = (i_paddr[1:0] == 2'h0);
   rd_val = 16'h0000;
   case (idx)
      `FSC_IDX_FB_HIGH:     rd_val = {13'h0000, fb_div_reg[18:16]};
      `FSC_IDX_FB_LOW:      rd_val = fb_div_reg[15:0];
      `FSC_IDX_SEED_DLY:    rd_val = {seed_apply_enable_reg, 1'b0,
                                      detector_delay_select_reg, 8'h00};
      `FSC_IDX_DEN_HIGH:    rd_val = fraction_denominator_reg[31:16];
      `FSC_IDX_DEN_LOW:     rd_val = fraction_denominator_reg[15:0];
      `FSC_IDX_SEED_HIGH:   rd_val = seed_high_reg;
      `FSC_IDX_SEED_LOW:    rd_val = seed_low_reg;
      `FSC_IDX_NUM_HIGH:    rd_val = fraction_numerator_reg[31:16];
      `FSC_IDX_NUM_LOW:     rd_val = fraction_numerator_reg[15:0];
      `FSC_IDX_PWR_MOD:     rd_val = {2'h0, first_output_power_reg,
                                      second_output_powerdown_reg,
                                      first_output_powerdown_reg,
                                      modulator_reset_ctl_reg, 2'h0,
                                      modulator_order_sel_reg};
      `FSC_IDX_SRC_BOOST:   rd_val = {3'h0, first_output_source_reg,
                                      output_boost_sel_reg, 3'h0,
                                      second_output_power_reg};
      `FSC_IDX_SECOND_SRC:  rd_val = {14'h0000, second_output_source_reg};
      `FSC_IDX_LOCK_KIND:   rd_val = {15'h0000, lock_indicator_kind_reg};
      `FSC_IDX_LOCK_DLY:    rd_val = lock_indicator_delay_reg;
      `FSC_IDX_SETTLE_HIGH: rd_val = post_reset_settle_count_reg[31:16];
      `FSC_IDX_SETTLE_LOW:  rd_val = post_reset_settle_count_reg[15:0];
      `FSC_IDX_SYNC_CTL:    rd_val = {15'h0000, phase_sync_mode_reg};
      `FSC_IDX_STATUS:      rd_val = {13'h0000, frac_on, o_divider_holdoff, o_lock};
      `FSC_IDX_ACC_HIGH:    rd_val = seed_accum_reg[31:16];
      `FSC_IDX_ACC_LOW:     rd_val = seed_accum_reg[15:0];
      default:              mapped = 1'b0;
   endcase
end
// ----------------------------------------
// Register writes and read data
// ----------------------------------------
always @(posedge i_clock or negedge i_reset_n)
begin
   if (!i_reset_n)
   begin
      o_prdata <= 32'h00000000;
      fb_div_reg <= `FSC_RST_FB_DIV;
      seed_apply_enable_reg <= 1'b0;
      detector_delay_select_reg <= `FSC_RST_DLY_SEL;
      fraction_denominator_reg <= `FSC_RST_DEN;
      seed_high_reg <= 16'h0000;
      seed_low_reg <= 16'h0000;
      fraction_numerator_reg <= 32'h00000000;
      first_output_power_reg <= `FSC_RST_PWR;
      second_output_powerdown_reg <= 1'b1;
      first_output_powerdown_reg <= 1'b0;
      modulator_reset_ctl_reg <= 1'b1;
      modulator_order_sel_reg <= 3'h0;
      first_output_source_reg <= `FSC_RST_SRC;
      output_boost_sel_reg <= 2'h0;
      second_output_power_reg <= `FSC_RST_PWR;
      second_output_source_reg <= `FSC_RST_SRC;
      lock_indicator_kind_reg <= 1'b1;
      lock_indicator_delay_reg <= `FSC_RST_LOCK_DLY;
      post_reset_settle_count_reg <= `FSC_RST_SETTLE;
      phase_sync_mode_reg <= 1'b0;
   end
   else
   begin
      if (setup)
      begin
         o_prdata <= mapped ? {16'h0000, rd_val} : 32'h00000000;
      end
      if (wr_en & mapped)
      begin
         case (idx)
            `FSC_IDX_FB_HIGH:    fb_div_reg[18:16] <= i_pwdata[2:0];
            `FSC_IDX_FB_LOW:     fb_div_reg[15:0] <= i_pwdata[15:0];
            `FSC_IDX_SEED_DLY:
            begin
               seed_apply_enable_reg <= i_pwdata[`FSC_SEED_EN_BIT];
               detector_delay_select_reg <= i_pwdata[`FSC_DLY_SEL_LSB+5:`FSC_DLY_SEL_LSB];
            end
            `FSC_IDX_DEN_HIGH:   fraction_denominator_reg[31:16] <= i_pwdata[15:0];
            `FSC_IDX_DEN_LOW:    fraction_denominator_reg[15:0] <= i_pwdata[15:0];
            `FSC_IDX_SEED_HIGH:  seed_high_reg <= i_pwdata[15:0];
            `FSC_IDX_SEED_LOW:   seed_low_reg <= i_pwdata[15:0];
            `FSC_IDX_NUM_HIGH:   fraction_numerator_reg[31:16] <= i_pwdata[15:0];
            `FSC_IDX_NUM_LOW:    fraction_numerator_reg[15:0] <= i_pwdata[15:0];
            `FSC_IDX_PWR_MOD:
            begin
               first_output_power_reg <= i_pwdata[`FSC_PWR1_LSB+5:`FSC_PWR1_LSB];
               second_output_powerdown_reg <= i_pwdata[`FSC_PD2_BIT];
               first_output_powerdown_reg <= i_pwdata[`FSC_PD1_BIT];
               modulator_reset_ctl_reg <= i_pwdata[`FSC_MRST_BIT];
               modulator_order_sel_reg <= i_pwdata[2:0];
            end
            `FSC_IDX_SRC_BOOST:
            begin
               first_output_source_reg <= i_pwdata[`FSC_SRC1_LSB+1:`FSC_SRC1_LSB];
               output_boost_sel_reg <= i_pwdata[`FSC_BOOST_LSB+1:`FSC_BOOST_LSB];
               second_output_power_reg <= i_pwdata[5:0];
            end
            `FSC_IDX_SECOND_SRC:  second_output_source_reg <= i_pwdata[1:0];
            `FSC_IDX_LOCK_KIND:   lock_indicator_kind_reg <= i_pwdata[0];
            `FSC_IDX_LOCK_DLY:    lock_indicator_delay_reg <= i_pwdata[15:0];
            `FSC_IDX_SETTLE_HIGH: post_reset_settle_count_reg[31:16] <= i_pwdata[15:0];
            `FSC_IDX_SETTLE_LOW:  post_reset_settle_count_reg[15:0] <= i_pwdata[15:0];
            `FSC_IDX_SYNC_CTL:    phase_sync_mode_reg <= i_pwdata[0];
            default:              phase_sync_mode_reg <= phase_sync_mode_reg;
         endcase
      end
   end
end
// ----------------------------------------
// Seed accumulator
// ----------------------------------------
// The low half commits the seed, so software writes the high half first.
always @(posedge i_clock or negedge i_reset_n)
begin
   if (!i_reset_n)
   begin
      seed_accum_reg <= 32'h00000000;
   end
   else if (modulator_reset_ctl_reg)
   begin
      seed_accum_reg <= 32'h00000000;
   end
   else if (wr_en & mapped & (idx == `FSC_IDX_SEED_LOW) & seed_apply_enable_reg)
   begin
      seed_accum_reg <= seed_accum_reg + {seed_high_reg, i_pwdata[15:0]};
   end
end
// ----------------------------------------
// Lock indicator and post-reset holdoff
// ----------------------------------------
always @(posedge i_clock or negedge i_reset_n)
begin
   if (!i_reset_n)
   begin
      lock_cnt_reg <= 16'h0000;
      o_lock <= 1'b0;
      mrst_prev_reg <= 1'b1;
      settle_cnt_reg <= 32'h00000000;
      o_divider_holdoff <= 1'b0;
   end
   else
   begin
      if (!lock_cond)
      begin
         lock_cnt_reg <= 16'h0000;
         o_lock <= 1'b0;
      end
      else if (lock_cnt_reg >= lock_indicator_delay_reg)
      begin
         o_lock <= 1'b1;
      end
      else if (i_pd_tick)
      begin
         lock_cnt_reg <= lock_cnt_reg + 16'h0001;
      end
      mrst_prev_reg <= modulator_reset_ctl_reg;
      // A count of zero or an integer order never holds, so integer users need not touch it.
      if (modulator_reset_ctl_reg)
      begin
         settle_cnt_reg <= 32'h00000000;
         o_divider_holdoff <= 1'b0;
      end
      else if (mrst_prev_reg & phase_sync_mode_reg & (order_eff != 3'h0) &
               (post_reset_settle_count_reg != 32'h00000000))
      begin
         settle_cnt_reg <= post_reset_settle_count_reg;
         o_divider_holdoff <= 1'b1;
      end
      else if (o_divider_holdoff & i_pd_tick)
      begin
         settle_cnt_reg <= settle_cnt_reg - 32'h00000001;
         if (settle_cnt_reg == 32'h00000001)
         begin
            o_divider_holdoff <= 1'b0;
         end
      end
   end
end
// ----------------------------------------
// Outputs to the analog core
// ----------------------------------------
always @(posedge i_clock or negedge i_reset_n)
begin
   if (!i_reset_n)
   begin
      o_divide_integer <= `FSC_RST_FB_DIV;
      o_fraction_num <= 32'h00000000;
      o_fraction_den <= `FSC_RST_DEN;
      o_seed_accum <= 32'h00000000;
      o_modulator_order <= 3'h0;
      o_modulator_reset <= 1'b1;
      o_detector_delay_select <= `FSC_RST_DLY_SEL;
      o_first_output_power <= `FSC_RST_PWR;
      o_second_output_power <= `FSC_RST_PWR;
      o_first_output_source <= `FSC_RST_SRC;
      o_second_output_source <= `FSC_RST_SRC;
      o_first_output_enable <= 1'b1;
      o_second_output_enable <= 1'b0;
      o_output_boost_sel <= 2'h0;
   end
   else
   begin
      o_divide_integer <= fb_div_reg;
      o_fraction_num <= frac_on ? fraction_numerator_reg : 32'h00000000;
      o_fraction_den <= fraction_denominator_reg;
      o_seed_accum <= seed_accum_reg;
      o_modulator_order <= frac_on ? order_eff : 3'h0;
      o_modulator_reset <= modulator_reset_ctl_reg;
      o_detector_delay_select <= detector_delay_select_reg;
      o_first_output_power <= first_output_power_reg;
      o_second_output_power <= second_output_power_reg;
      o_first_output_source <= first_output_source_reg;
      o_second_output_source <= second_output_source_reg;
      o_first_output_enable <= ~first_output_powerdown_reg &
                               (first_output_source_reg != `FSC_SRC_HIZ) &
                               (first_output_source_reg != `FSC_SRC_RSVD);
      o_second_output_enable <= ~second_output_powerdown_reg &
                                (second_output_source_reg != `FSC_SRC_HIZ);
      o_output_boost_sel <= output_boost_sel_reg;
   end
end
endmodule // fsc_control_regs

//--- dv/fsc_control_regs_sva.sv
// Concurrent checks on the ports of the synthesizer control bank.
`timescale 1ns/10ps
module fsc_control_regs_sva
(
   input wire        i_clock,
   input wire        i_reset_n,
   input wire        i_psel,
   input wire        i_penable,
   input wire        i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   input wire        i_cal_done,
   input wire        i_vtune_ok,
   input wire        i_pd_tick,
   input wire        o_pready,
   input wire        o_pslverr,
   input wire [31:0] o_prdata,
   input wire [18:0] o_divide_integer,
   input wire [31:0] o_fraction_num,
   input wire [31:0] o_fraction_den,
   input wire [31:0] o_seed_accum,
   input wire [2:0]  o_modulator_order,
   input wire        o_modulator_reset,
   input wire [5:0]  o_detector_delay_select,
   input wire [5:0]  o_first_output_power,
   input wire [5:0]  o_second_output_power,
   input wire [1:0]  o_first_output_source,
   input wire [1:0]  o_second_output_source,
   input wire        o_first_output_enable,
   input wire        o_second_output_enable,
   input wire [1:0]  o_output_boost_sel,
   input wire        o_lock,
   input wire        o_divider_holdoff
);
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   a_ready_always: assert property (o_pready)
      else $error("pready low");
   a_misaligned_refused: assert property (
      i_psel && i_penable && i_paddr[1:0] != 2'h0 |-> o_pslverr)
      else $error("misaligned access not refused");
   a_error_reads_zero: assert property (
      i_psel && i_penable && o_pslverr |-> o_prdata == 32'h0)
      else $error("refused access returned data");
   a_order_legal: assert property (o_modulator_order <= 3'h4)
      else $error("reserved order reached the modulator");
   a_reset_means_int: assert property (o_modulator_reset |->
      o_modulator_order == 3'h0 && o_fraction_num == 32'h0)
      else $error("fraction active while modulator held in reset");
   a_seed_cleared: assert property (o_modulator_reset &&
      $past(o_modulator_reset) |-> o_seed_accum == 32'h0)
      else $error("seed not cleared by modulator reset");
   a_first_hiz_off: assert property (o_first_output_source[1] |->
      !o_first_output_enable)
      else $error("first output driven from reserved or hiz source");
   a_second_hiz_off: assert property (o_second_output_source == 2'h3 |->
      !o_second_output_enable)
      else $error("second output driven in hiz");
   a_lock_drop: assert property (!i_cal_done |=> !o_lock)
      else $error("lock held without calibration");
   a_holdoff_start: assert property ($rose(o_divider_holdoff) |->
      !o_modulator_reset && o_modulator_order != 3'h0)
      else $error("holdoff began outside fractional release");
   a_holdoff_keeps: assert property (o_divider_holdoff && !i_pd_tick &&
      !o_modulator_reset |=> o_divider_holdoff || o_modulator_reset)
      else $error("holdoff ended without a tick");
   c_write: cover property (i_psel && i_penable && i_pwrite);
   c_lock: cover property ($rose(o_lock));
   c_holdoff: cover property ($fell(o_divider_holdoff));
endmodule // fsc_control_regs_sva

bind fsc_control_regs fsc_control_regs_sva u_sva (.*);

//--- dv/testbench.sv
// Self-checking bench for the synthesizer control register bank.
`timescale 1ns/10ps
`include "fsc_defines.vh"
module testbench;
   logic        i_clock = 1'h0, i_reset_n = 1'h0, i_psel = 1'h0, i_penable = 1'h0;
   logic        i_pwrite = 1'h0, i_cal_done = 1'h0, i_vtune_ok = 1'h0, i_pd_tick = 1'h0;
   logic [11:0] i_paddr = 12'h0;
   logic [31:0] i_pwdata = 32'h0;
   wire         o_pready, o_pslverr, o_first_output_enable, o_second_output_enable;
   wire         o_modulator_reset, o_lock, o_divider_holdoff;
   wire  [31:0] o_prdata, o_fraction_num, o_fraction_den, o_seed_accum;
   wire  [18:0] o_divide_integer;
   wire  [5:0]  o_detector_delay_select, o_first_output_power, o_second_output_power;
   wire  [2:0]  o_modulator_order;
   wire  [1:0]  o_first_output_source, o_second_output_source, o_output_boost_sel;
   int          n_mismatch = 0, num_checks = 0;
   logic [31:0] rd;
   logic        er;
   fsc_control_regs dut (.*);
   // ----------------------------------------
   // Bus and compare tasks
   // ----------------------------------------
   function automatic logic [11:0] ba(input logic [9:0] i);
      return {i, 2'h0};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // The request is held until pready is seen high at a rising edge.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge i_clock);
      i_psel <= 1'h1;
      i_penable <= 1'h0;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= wd;
      @(posedge i_clock);
      i_penable <= 1'h1;
      do
         @(posedge i_clock);
      while (o_pready !== 1'h1);
      rd = o_prdata;
      er = o_pslverr;
      i_psel <= 1'h0;
      i_penable <= 1'h0;
   endtask
   task automatic wr(input logic [9:0] i, input logic [31:0] d);
      apb(1'h1, ba(i), d);
   endtask
   task automatic rdchk(input logic [9:0] i, input logic [31:0] exp);
      apb(1'h0, ba(i), 32'h0);
      chk(rd, exp);
   endtask
   task automatic probe(input logic [9:0] i, input logic [31:0] r, input logic [31:0] m);
      rdchk(i, r);
      wr(i, 32'hffff);
      rdchk(i, m);
   endtask
   task automatic st();
      repeat (3) @(posedge i_clock);
      #1;
   endtask
   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge i_clock);
         i_pd_tick <= 1'h1;
         @(posedge i_clock);
         i_pd_tick <= 1'h0;
      end
   endtask
   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // Clock, watchdog and tests
   // ----------------------------------------
   initial forever #5 i_clock = ~i_clock;
   // The tests need about four hundred cycles; ten thousand means a hang.
   initial
   begin
      #100000;
      n_mismatch++;
      tally_and_finish();
   end
   initial
   begin
      repeat (6) @(posedge i_clock);
      i_reset_n <= 1'h1;
      st();
      chk(o_divide_integer, 32'h64);
      chk({o_first_output_enable, o_second_output_enable}, 32'h2);
      chk({o_first_output_source, o_second_output_source}, 32'h5);
      chk(o_modulator_reset, 32'h1);
      probe(`FSC_IDX_FB_HIGH, 32'h0, 32'h7);
      probe(`FSC_IDX_FB_LOW, 32'h64, 32'hffff);
      probe(`FSC_IDX_SEED_DLY, 32'h200, 32'hbf00);
      probe(`FSC_IDX_DEN_HIGH, 32'hffff, 32'hffff);
      probe(`FSC_IDX_DEN_LOW, 32'hffff, 32'hffff);
      probe(`FSC_IDX_NUM_HIGH, 32'h0, 32'hffff);
      probe(`FSC_IDX_NUM_LOW, 32'h0, 32'hffff);
      probe(`FSC_IDX_PWR_MOD, 32'h1fa0, 32'h3fe7);
      probe(`FSC_IDX_SRC_BOOST, 32'h81f, 32'h1e3f);
      probe(`FSC_IDX_SECOND_SRC, 32'h1, 32'h3);
      probe(`FSC_IDX_LOCK_KIND, 32'h1, 32'h1);
      probe(`FSC_IDX_LOCK_DLY, 32'h3e8, 32'hffff);
      probe(`FSC_IDX_SETTLE_HIGH, 32'h0, 32'hffff);
      probe(`FSC_IDX_SETTLE_LOW, 32'hc350, 32'hffff);
      st();
      chk(o_divide_integer, 32'h7ffff);
      chk(o_fraction_den, 32'hffffffff);
      chk(o_detector_delay_select, 32'h3f);
      chk({o_first_output_power, o_second_output_power}, 32'hfff);
      chk(o_output_boost_sel, 32'h3);
      apb(1'h0, 12'h0fc, 32'h0);
      chk(rd, 32'h0);
      chk(er, 32'h1);
      apb(1'h1, 12'h091, 32'h5);
      chk(er, 32'h1);
      rdchk(`FSC_IDX_FB_LOW, 32'hffff);
      wr(`FSC_IDX_PWR_MOD, 32'h1);
      wr(`FSC_IDX_SEED_DLY, 32'h200);
      wr(`FSC_IDX_SEED_HIGH, 32'h1);
      wr(`FSC_IDX_SEED_LOW, 32'h2);
      st();
      chk(o_seed_accum, 32'h0);
      wr(`FSC_IDX_SEED_DLY, 32'h8200);
      repeat (2)
      begin
         wr(`FSC_IDX_SEED_HIGH, 32'h1);
         wr(`FSC_IDX_SEED_LOW, 32'h2);
      end
      st();
      chk(o_seed_accum, 32'h20004);
      rdchk(`FSC_IDX_ACC_LOW, 32'h4);
      wr(`FSC_IDX_PWR_MOD, 32'h21);
      wr(`FSC_IDX_PWR_MOD, 32'h1);
      st();
      chk(o_seed_accum, 32'h0);
      wr(`FSC_IDX_NUM_HIGH, 32'h1234);
      wr(`FSC_IDX_NUM_LOW, 32'h5678);
      wr(`FSC_IDX_DEN_LOW, 32'h9abc);
      for (int k = 0; k < 8; k++)
      begin
         wr(`FSC_IDX_PWR_MOD, k);
         st();
         chk(o_modulator_order, (k < 5) ? k : 0);
         chk(o_fraction_num, (k > 0 && k < 5) ? 32'h12345678 : 32'h0);
      end
      chk(o_fraction_den, 32'hffff9abc);
      wr(`FSC_IDX_PWR_MOD, 32'h1);
      for (int s = 0; s < 4; s++)
      begin
         wr(`FSC_IDX_SRC_BOOST, s << 11);
         wr(`FSC_IDX_SECOND_SRC, s);
         st();
         chk({o_first_output_source, o_second_output_source}, s * 5);
         chk({o_first_output_enable, o_second_output_enable}, {s < 2, s != 3});
      end
      wr(`FSC_IDX_SRC_BOOST, 32'h800);
      wr(`FSC_IDX_SECOND_SRC, 32'h1);
      wr(`FSC_IDX_PWR_MOD, 32'h41);
      st();
      chk({o_first_output_enable, o_second_output_enable}, 32'h1);
      wr(`FSC_IDX_PWR_MOD, 32'h81);
      st();
      chk({o_first_output_enable, o_second_output_enable}, 32'h2);
      wr(`FSC_IDX_LOCK_DLY, 32'h3);
      i_cal_done <= 1'h1;
      tick(5);
      st();
      chk(o_lock, 32'h0);
      @(posedge i_clock);
      i_vtune_ok <= 1'h1;
      tick(2);
      st();
      chk(o_lock, 32'h0);
      tick(1);
      st();
      chk(o_lock, 32'h1);
      wr(`FSC_IDX_LOCK_KIND, 32'h0);
      i_vtune_ok <= 1'h0;
      st();
      chk(o_lock, 32'h1);
      @(posedge i_clock);
      i_cal_done <= 1'h0;
      st();
      chk(o_lock, 32'h0);
      wr(`FSC_IDX_SYNC_CTL, 32'h1);
      wr(`FSC_IDX_SETTLE_HIGH, 32'h0);
      for (int c = 3; c >= 0; c -= 3)
      begin
         wr(`FSC_IDX_SETTLE_LOW, c);
         wr(`FSC_IDX_PWR_MOD, 32'h21);
         wr(`FSC_IDX_PWR_MOD, 32'h1);
         st();
         chk(o_divider_holdoff, c != 0);
         tick(2);
         st();
         chk(o_divider_holdoff, c != 0);
         tick(1);
         st();
         chk(o_divider_holdoff, 32'h0);
      end
      tally_and_finish();
   end
endmodule // testbench
